// [bench/pin_board.sv]
// Purpose: board circuitry on the port pins
// Assumes: board drives every pin the block releases
// Notes: no pulls, board level shows only where the block does not drive
`timescale 1ns/1ps
module pin_board (
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe,
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_b,
  output logic [7:0] a_in,
  output logic [7:0] b_in
);
  // wire level: block wins where it drives
  assign a_in = (a_oe & a_out) | (~a_oe & ext_a);
  assign b_in = (b_oe & b_out) | (~b_oe & ext_b);
endmodule

// [bench/pin_select_monitor.sv]
// Purpose: port-level assertions for the port A/B pin selector
// Assumes: one clock, asynchronous active-low reset
// Notes: bound from the testbench top file
`timescale 1ns/1ps
module pin_select_monitor
  import pin_select_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic HW_STANDBY,
  input wire logic SW_STANDBY,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [7:0] PORT_B_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // read address accepted this edge
  logic ar_hs;
  assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  chk_hws_inputs: assert property (HW_STANDBY [*3] |-> PORT_B_OE == 8'h00)
    else $error("port B not input in hardware standby");
  // a write landing one edge back may still move the pins
  chk_sws_hold: assert property (SW_STANDBY && $past(SW_STANDBY) && !$past(S_AXI_BVALID)
    && !$past(HW_STANDBY) && !$past(HW_STANDBY, 2) |-> $stable(PORT_B_OE))
    else $error("port B drive moved in software standby");
  chk_wo_ones: assert property (ar_hs && S_AXI_ARADDR[19:0] == PORT_B_DIRECTION_OFS
    |=> S_AXI_RVALID && S_AXI_RDATA[7:0] == WRITE_ONLY_READ && S_AXI_RRESP == RESP_OKAY)
    else $error("direction read not all ones");
  chk_unmapped_err: assert property (ar_hs && S_AXI_ARADDR[19:12] == 8'h00
    |=> S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR)
    else $error("unmapped read not refused");
  // both held one edge after the handshake, the response one edge later
  chk_b_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    && !S_AXI_BVALID |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  chk_b_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  chk_r_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  chk_ar_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while answering");
endmodule

// [bench/port_a_b_pin_function_select_tb.sv]
// Purpose: self-checking bench for the port A/B pin selector
// Assumes: AXI4-Lite master here, board model on the pins
// Notes: fixed seed, random port data mixed with corner cases
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module port_a_b_pin_function_select_tb;
  import pin_select_pkg::*;
  logic CLK = 0, RESET_N = 0, HW_STANDBY = 0, SW_STANDBY = 0;
  logic [31:0] S_AXI_AWADDR = 0, S_AXI_WDATA = 0, S_AXI_ARADDR = 0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hF, ADDR_HIGH = 4'hA, EXT_CLOCK;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, DMA_TRANSFER_END = 2'b10, ROW_STROBE = 2'b01;
  logic [2:0] TIMER_A_COMPARE = 3'b101, TIMER_B_COMPARE = 3'b010, TIMER_A_CAPTURE, TIMER_B_CAPTURE;
  logic [7:0] PATTERN_OUTPUT = 0, PORT_A_IN, PORT_A_OUT, PORT_A_OE, PORT_B_IN, PORT_B_OUT, PORT_B_OE;
  logic [7:0] ext_a = 8'hFF, ext_b = 0;
  logic [3:0] em [4] = '{4'h1, 4'h4, 4'h2, 4'h8};
  int bad_count = 0, checked = 0, seed = 32'hfa3d;
  port_a_b_pin_function_select dut (.*);
  pin_board board (.a_out(PORT_A_OUT), .a_oe(PORT_A_OE), .b_out(PORT_B_OUT), .b_oe(PORT_B_OE),
    .ext_a(ext_a), .ext_b(ext_b), .a_in(PORT_A_IN), .b_in(PORT_B_IN));
  initial forever #20 CLK = ~CLK;
  task close_out;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wt(input int k);
    repeat (k) @(posedge CLK);
  endtask
  // write: address and data together, response taken after one stall cycle
  task axw(input logic [19:0] a, input logic [31:0] d);
    int n;
    logic ga, gw;
    ga = 0; gw = 0; n = 0;
    @(posedge CLK);
    S_AXI_AWADDR <= {12'h000, a}; S_AXI_WDATA <= d; S_AXI_AWVALID <= 1; S_AXI_WVALID <= 1;
    while (!(ga && gw) && n < 50) begin
      @(posedge CLK); n++;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin ga = 1; S_AXI_AWVALID <= 0; end
      if (S_AXI_WVALID && S_AXI_WREADY) begin gw = 1; S_AXI_WVALID <= 0; end
    end
    while (S_AXI_BVALID !== 1'b1 && n < 50) begin @(posedge CLK); n++; end
    S_AXI_BREADY <= 1;
    @(posedge CLK);
    `CHK("bresp", RESP_OKAY, S_AXI_BRESP)
    S_AXI_BREADY <= 0;
    if (n >= 50) begin bad_count++; close_out; end
  endtask
  task axr(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLK);
    S_AXI_ARADDR <= {12'h000, a}; S_AXI_ARVALID <= 1;
    while (!(S_AXI_ARVALID && S_AXI_ARREADY) && n < 50) begin @(posedge CLK); n++; end
    S_AXI_ARVALID <= 0;
    while (S_AXI_RVALID !== 1'b1 && n < 50) begin @(posedge CLK); n++; end
    S_AXI_RREADY <= 1;
    @(posedge CLK);
    d = S_AXI_RDATA; r = S_AXI_RRESP;
    S_AXI_RREADY <= 0;
    if (n >= 50) begin bad_count++; close_out; end
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    close_out;
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] dir, val;
    repeat (8) @(posedge CLK);
    RESET_N <= 1;
    ext_b <= 8'($random(seed)); PATTERN_OUTPUT <= 8'($random(seed));
    wt(4);
    axr(PORT_B_DIRECTION_OFS, d, r); `CHK("pb dir read", 8'hFF, d[7:0])
    `CHK("pb oe reset", 8'h00, PORT_B_OE)
    axr(PORT_B_OUTPUT_VALUE_OFS, d, r); `CHK("pb pins", ext_b, d[7:0])
    axr(20'h0_0010, d, r); `CHK("unmapped", RESP_SLVERR, r)
    // port B lanes sit in byte 2
    for (int k = 0; k < 4; k++) begin
      dir = 8'($random(seed)); val = 8'($random(seed));
      axw(PORT_B_DIRECTION_OFS, {8'h00, dir, 16'h0000});
      axw(PORT_B_OUTPUT_VALUE_OFS, {8'h00, val, 16'h0000});
      wt(4);
      `CHK("pb oe", dir, PORT_B_OE)
      `CHK("pb out", val & dir, PORT_B_OUT & dir)
      axr(PORT_B_OUTPUT_VALUE_OFS, d, r); `CHK("pb mix", (val & dir) | (ext_b & ~dir), d[7:0])
    end
    SW_STANDBY <= 1; wt(4);
    `CHK("pb sws", dir, PORT_B_OE)
    SW_STANDBY <= 0; HW_STANDBY <= 1; wt(4);
    `CHK("pb hws", 8'h00, PORT_B_OE)
    HW_STANDBY <= 0;
    axw(PORT_B_DIRECTION_OFS, 32'h00FF_0000);
    axr(PORT_B_OUTPUT_VALUE_OFS, d, r); `CHK("pb data clr", 8'h00, d[7:0])
    // pattern pins have their direction set first
    axw(PORT_A_DIRECTION_OFS, 32'h0000_00F0);
    axw(PORT_A_OUTPUT_VALUE_OFS, 32'h0000_005A);
    axw(PATTERN_ENABLE_OFS, 32'h0000_00CC); wt(4);
    `CHK("pa oe", 8'hF0, PORT_A_OE)
    `CHK("pa out", ((PATTERN_OUTPUT & 8'hCC) | 8'h12) & 8'hF0, PORT_A_OUT & 8'hF0)
    axw(PATTERN_ENABLE_OFS, 0); axw(PORT_A_DIRECTION_OFS, 0);
    // compare on PA2, PA5, PA6; capture on PA4 and PA3; PA7 capture blocked by duty mode
    axw(TIMER_SETUP_OFS, 32'h0012_2821); wt(4);
    `CHK("pa cmp oe", 8'h64, PORT_A_OE)
    `CHK("pa cmp", 3'b111, {PORT_A_OUT[6], PORT_A_OUT[5], PORT_A_OUT[2]})
    `CHK("cap a", 3'b010, TIMER_A_CAPTURE)
    `CHK("cap b", 3'b001, TIMER_B_CAPTURE)
    axw(TIMER_SETUP_OFS, 0);
    for (int k = 0; k < 4; k++) begin
      axw(CLOCK_SETUP_OFS, 32'(k + 4)); wt(4);
      `CHK("ext clk pre", 4'(1 << k), EXT_CLOCK)
      axw(CLOCK_SETUP_OFS, 32'((5 + k % 3) << (9 + 3 * k))); wt(4);
      `CHK("ext clk 8b", em[k], EXT_CLOCK)
    end
    axw(CLOCK_SETUP_OFS, 0); axw(TIMER_SETUP_OFS, 32'h0020_0000); wt(4);
    `CHK("phase clk", 4'h3, EXT_CLOCK)
    axw(TIMER_SETUP_OFS, 0);
    axw(SYSTEM_SETUP_OFS, 32'h0000_003E); wt(4);
    `CHK("dma oe", 2'b11, PORT_A_OE[1:0])
    `CHK("dma out", DMA_TRANSFER_END, PORT_A_OUT[1:0])
    axw(SYSTEM_SETUP_OFS, 32'h0000_0001); wt(4);
    `CHK("addr oe", 4'hF, PORT_A_OE[7:4])
    `CHK("addr out", 4'h5, PORT_A_OUT[7:4])
    axw(SYSTEM_SETUP_OFS, 32'h0000_000F); wt(4);
    `CHK("addr20 only", 4'h8, PORT_A_OE[7:4])
    axw(PORT_B_DIRECTION_OFS, 0); axw(SYSTEM_SETUP_OFS, 32'h0000_004E); wt(4);
    `CHK("row oe", 2'b11, PORT_B_OE[3:2])
    `CHK("row out", 2'b10, {PORT_B_OUT[3], PORT_B_OUT[2]})
    close_out;
  end
endmodule
bind port_a_b_pin_function_select pin_select_monitor mon (.*);

// [design/port_a_b_pin_function_select.sv]
// Purpose: port A/B pin-function selection with AXI4-Lite register access
// Assumes: pins already resolved outside from dout/oe; peripherals sit beside this block
// Notes: one clock, asynchronous active-low reset plus hardware standby clear
// Notes on behaviour
// - port A: ddr selects input, output or pattern
// - timer A compare output overrides port settings
// - timer B compare output overrides port settings
// - timer A capture input taken from pin
// - timer B capture only without duty mode
// - expanded modes: port A bit 7 drives A20
// - expanded modes: address enable 0 drives address
// - bit 3 feeds external clock D
// - bit 2 feeds external clock C
// - bit 1 feeds external clock B
// - bit 0 feeds external clock A
// - DMA external request drives transfer-end on pin
// - reset or hardware standby makes port B inputs
// - dram attached: chip selects become row strobes
// - port B direction bit 1 means output
// - port B direction reads all ones
// - direction clears on reset and hardware standby, software standby keeps it
// - software standby keeps output pins driven
// - data read mixes stored bits and pin levels
// - general output drives stored data bit
// - expanded modes fix bit 7 direction one
`timescale 1ns/1ps
module port_a_b_pin_function_select
  import pin_select_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic HW_STANDBY,
  input wire logic SW_STANDBY,
  // AXI4-Lite slave
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // peripheral side
  input wire logic [7:0] PATTERN_OUTPUT,
  input wire logic [2:0] TIMER_A_COMPARE,
  input wire logic [2:0] TIMER_B_COMPARE,
  input wire logic [3:0] ADDR_HIGH,
  input wire logic [1:0] DMA_TRANSFER_END,
  input wire logic [1:0] ROW_STROBE,
  output logic [2:0] TIMER_A_CAPTURE,
  output logic [2:0] TIMER_B_CAPTURE,
  output logic [3:0] EXT_CLOCK,
  // pins
  input wire logic [7:0] PORT_A_IN,
  output logic [7:0] PORT_A_OUT,
  output logic [7:0] PORT_A_OE,
  input wire logic [7:0] PORT_B_IN,
  output logic [7:0] PORT_B_OUT,
  output logic [7:0] PORT_B_OE
);

  // register state
  logic [7:0] pb_dir_ff, nxt_pb_dir;
  logic [7:0] pb_val_ff, nxt_pb_val;
  logic [7:0] pa_dir_ff, nxt_pa_dir;
  logic [7:0] pa_val_ff, nxt_pa_val;
  logic [15:0] pat_en_ff, nxt_pat_en;
  logic [31:0] tim_ff, nxt_tim;
  logic [31:0] clk_ff, nxt_clk;
  logic [7:0] sys_ff, nxt_sys;
  // bus state
  logic aw_hold_ff, nxt_aw_hold;
  logic w_hold_ff, nxt_w_hold;
  logic [19:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  // pin synchronisers, first stage read only by second
  logic [7:0] pa_s1_ff, pa_s2_ff, pb_s1_ff, pb_s2_ff;
  // output registers
  pin_drive_s pa_drv_ff, nxt_pa_drv, pb_drv_ff, nxt_pb_drv;
  logic [2:0] cap_a_ff, nxt_cap_a, cap_b_ff, nxt_cap_b;
  logic [3:0] ext_ff, nxt_ext;

  timer_chan_s chan [3];
  logic expanded;
  logic do_write;
  logic [19:0] wr_addr;

  // unpack timer channel fields from the setup register
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      chan[c].a_select_field = tim_ff[TS_A_SEL_POS + 3*c +: 3];
      chan[c].b_select_field = tim_ff[TS_B_SEL_POS + 3*c +: 3];
      chan[c].duty_mode_bit = tim_ff[TS_DUTY_POS + c];
    end
  end

  assign expanded = sys_ff[SS_EXPANDED];
  assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_addr = aw_addr_ff;

  // bus next state: address and data taken in either order, one write at a time
  always_comb begin
    logic [31:0] rd;
    logic hit;
    rd = 32'h0000_0000;
    hit = 1'b1;
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (S_AXI_AWVALID && !aw_hold_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_aw_addr = S_AXI_AWADDR[19:0];
    end
    if (S_AXI_WVALID && !w_hold_ff) begin
      nxt_w_hold = 1'b1;
      nxt_w_data = S_AXI_WDATA;
      nxt_w_strb = S_AXI_WSTRB;
    end
    if (do_write) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      case ({wr_addr[19:2], 2'b00})
        {PORT_B_DIRECTION_OFS[19:2], 2'b00}, {PORT_B_OUTPUT_VALUE_OFS[19:2], 2'b00},
        PORT_A_DIRECTION_OFS, PORT_A_OUTPUT_VALUE_OFS, PATTERN_ENABLE_OFS,
        TIMER_SETUP_OFS, CLOCK_SETUP_OFS, SYSTEM_SETUP_OFS, PORT_A_PIN_OFS: nxt_bresp = RESP_OKAY;
        default: nxt_bresp = RESP_SLVERR;
      endcase
    end
    if (bvalid_ff && S_AXI_BREADY) begin
      nxt_bvalid = 1'b0;
    end
    // read mux, live pin data from synchronised levels
    case ({S_AXI_ARADDR[19:2], 2'b00})
      {PORT_B_DIRECTION_OFS[19:2], 2'b00}: rd = {24'h00_0000, WRITE_ONLY_READ};
      {PORT_B_OUTPUT_VALUE_OFS[19:2], 2'b00}: rd = {24'h00_0000,
        (pb_val_ff & pb_dir_ff) | (pb_s2_ff & ~pb_dir_ff)};
      PORT_A_DIRECTION_OFS: rd = {24'h00_0000, WRITE_ONLY_READ};
      PORT_A_OUTPUT_VALUE_OFS: rd = {24'h00_0000, (pa_val_ff & pa_dir_ff) | (pa_s2_ff & ~pa_dir_ff)};
      PATTERN_ENABLE_OFS: rd = {16'h0000, pat_en_ff};
      TIMER_SETUP_OFS: rd = tim_ff;
      CLOCK_SETUP_OFS: rd = clk_ff;
      SYSTEM_SETUP_OFS: rd = {24'h00_0000, sys_ff};
      PORT_A_PIN_OFS: rd = {16'h0000, pa_drv_ff.oe, pa_s2_ff};
      default: hit = 1'b0;
    endcase
    if (S_AXI_ARVALID && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rd;
      nxt_rresp = hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && S_AXI_RREADY) begin
      nxt_rvalid = 1'b0;
    end
  end

  // register writes; port B offsets are byte-packed inside their word
  always_comb begin
    logic [1:0] ln;
    logic [7:0] bv;
    ln = wr_addr[1:0];
    bv = w_data_ff[8*ln +: 8];
    nxt_pb_dir = pb_dir_ff;
    nxt_pb_val = pb_val_ff;
    nxt_pa_dir = pa_dir_ff;
    nxt_pa_val = pa_val_ff;
    nxt_pat_en = pat_en_ff;
    nxt_tim = tim_ff;
    nxt_clk = clk_ff;
    nxt_sys = sys_ff;
    if (do_write) begin
      case ({wr_addr[19:2], 2'b00})
        {PORT_B_DIRECTION_OFS[19:2], 2'b00}: if (w_strb_ff[ln]) nxt_pb_dir = bv;
        {PORT_B_OUTPUT_VALUE_OFS[19:2], 2'b00}: if (w_strb_ff[ln]) nxt_pb_val = bv;
        PORT_A_DIRECTION_OFS: if (w_strb_ff[0]) nxt_pa_dir = w_data_ff[7:0];
        PORT_A_OUTPUT_VALUE_OFS: if (w_strb_ff[0]) nxt_pa_val = w_data_ff[7:0];
        PATTERN_ENABLE_OFS: begin
          if (w_strb_ff[0]) nxt_pat_en[7:0] = w_data_ff[7:0];
          if (w_strb_ff[1]) nxt_pat_en[15:8] = w_data_ff[15:8];
        end
        TIMER_SETUP_OFS: begin
          for (int b = 0; b < 4; b++) if (w_strb_ff[b]) nxt_tim[8*b +: 8] = w_data_ff[8*b +: 8];
        end
        CLOCK_SETUP_OFS: begin
          for (int b = 0; b < 4; b++) if (w_strb_ff[b]) nxt_clk[8*b +: 8] = w_data_ff[8*b +: 8];
        end
        SYSTEM_SETUP_OFS: if (w_strb_ff[0]) nxt_sys = w_data_ff[7:0];
        default: nxt_sys = sys_ff;
      endcase
    end
    // bit 7 direction held at one while expanded
    if (expanded) nxt_pa_dir[7] = 1'b1;
  end

  // pin function selection, registered so writes reach pins the next cycle
  always_comb begin
    logic [7:0] a_oe, a_do, b_oe, b_do;
    logic [2:0] pre_any;
    logic [3:0] pre_hit;
    logic [3:0] ext8;
    logic tm_drives;
    a_oe = 8'h00;
    a_do = 8'h00;
    b_oe = 8'h00;
    b_do = 8'h00;
    pre_hit = 4'h0;
    ext8 = 4'h0;
    pre_any = 3'h0;
    tm_drives = 1'b0;
    // general and pattern selection per port A pin
    for (int i = 0; i < 8; i++) begin
      a_oe[i] = pa_dir_ff[i];
      a_do[i] = (pa_dir_ff[i] && pat_en_ff[i]) ? PATTERN_OUTPUT[i] : pa_val_ff[i];
    end
    // timer compare overrides; channel c uses A on pin 2c+2, B on pin 2c+3
    for (int c = 0; c < 3; c++) begin
      tm_drives = chan[c].duty_mode_bit ||
                  (!chan[c].a_select_field[2] && chan[c].a_select_field[1:0] != 2'b00);
      if (tm_drives) begin
        a_oe[2*c+2] = 1'b1;
        a_do[2*c+2] = TIMER_A_COMPARE[c];
      end
      if (!chan[c].b_select_field[2] && chan[c].b_select_field[1:0] != 2'b00) begin
        a_oe[2*c+3] = 1'b1;
        a_do[2*c+3] = TIMER_B_COMPARE[c];
      end
    end
    // transfer-end outputs on bits 1 and 0
    for (int d = 0; d < 2; d++) begin
      if (sys_ff[SS_DMA0_EXT + d]) begin
        a_oe[d] = 1'b1;
        a_do[d] = DMA_TRANSFER_END[d];
      end
    end
    // expanded-mode address lines take priority over everything
    if (expanded) begin
      a_oe[7] = 1'b1;
      a_do[7] = ADDR_HIGH[0];
      for (int k = 1; k < 4; k++) begin
        if (!sys_ff[SS_ADDR21_EN + k - 1]) begin
          a_oe[7-k] = 1'b1;
          a_do[7-k] = ADDR_HIGH[k];
        end
      end
    end
    // port B general, pattern and row strobe
    for (int i = 0; i < 8; i++) begin
      b_oe[i] = pb_dir_ff[i];
      b_do[i] = (pb_dir_ff[i] && pat_en_ff[8+i]) ? PATTERN_OUTPUT[i] : pb_val_ff[i];
    end
    if (sys_ff[SS_DRAM]) begin
      b_oe[3] = 1'b1;
      b_do[3] = ROW_STROBE[0];
      b_oe[2] = 1'b1;
      b_do[2] = ROW_STROBE[1];
    end
    // external clock pin routing
    for (int c = 0; c < 3; c++) begin
      pre_any = clk_ff[CS_PRE_POS + 3*c +: 3];
      pre_hit[0] = pre_hit[0] | (pre_any == PRE_CLK_A);
      pre_hit[1] = pre_hit[1] | (pre_any == PRE_CLK_B);
      pre_hit[2] = pre_hit[2] | (pre_any == PRE_CLK_C);
      pre_hit[3] = pre_hit[3] | (pre_any == PRE_CLK_D);
    end
    for (int e = 0; e < 4; e++) begin
      ext8[e] = clk_ff[CS_EIGHT_POS + 3*e + 2] && (clk_ff[CS_EIGHT_POS + 3*e +: 2] != 2'b00);
    end
    nxt_ext[0] = (tim_ff[TS_PHASE_POS] || pre_hit[0] || ext8[0]) && pa_s2_ff[0];
    nxt_ext[1] = (tim_ff[TS_PHASE_POS] || pre_hit[1] || ext8[2]) && pa_s2_ff[1];
    nxt_ext[2] = (pre_hit[2] || ext8[1]) && pa_s2_ff[2];
    nxt_ext[3] = (pre_hit[3] || ext8[3]) && pa_s2_ff[3];
    // capture inputs from timer pins
    for (int c = 0; c < 3; c++) begin
      nxt_cap_a[c] = chan[c].a_select_field[2] && pa_s2_ff[2*c+2];
      nxt_cap_b[c] = chan[c].b_select_field[2] && !chan[c].duty_mode_bit && pa_s2_ff[2*c+3];
    end
    nxt_pa_drv.oe = a_oe;
    nxt_pa_drv.dout = a_do;
    nxt_pb_drv.oe = b_oe;
    nxt_pb_drv.dout = b_do;
  end

  // registers; hardware standby clears like reset except system setup bits 3:0 and expanded bit 7 direction, software standby changes nothing
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pb_dir_ff <= PORT_B_DIRECTION_RST;
      pb_val_ff <= PORT_B_OUTPUT_VALUE_RST;
      pa_dir_ff <= PORT_A_DIRECTION_RST;
      pa_val_ff <= 8'h00;
      pat_en_ff <= 16'h0000;
      tim_ff <= TIMER_SETUP_RST;
      clk_ff <= CLOCK_SETUP_RST;
      sys_ff <= SYSTEM_SETUP_RST;
      pa_drv_ff <= '0;
      pb_drv_ff <= '0;
      cap_a_ff <= 3'h0;
      cap_b_ff <= 3'h0;
      ext_ff <= 4'h0;
    end else if (HW_STANDBY) begin
      pb_dir_ff <= PORT_B_DIRECTION_RST;
      pb_val_ff <= PORT_B_OUTPUT_VALUE_RST;
      pa_dir_ff <= expanded ? 8'h80 : PORT_A_DIRECTION_RST;
      pa_val_ff <= 8'h00;
      pat_en_ff <= 16'h0000;
      tim_ff <= TIMER_SETUP_RST;
      clk_ff <= CLOCK_SETUP_RST;
      sys_ff <= {sys_ff[7:1] & 7'h07, sys_ff[0]};
      pa_drv_ff <= '0;
      pb_drv_ff <= '0;
      cap_a_ff <= 3'h0;
      cap_b_ff <= 3'h0;
      ext_ff <= 4'h0;
    end else begin
      pb_dir_ff <= nxt_pb_dir;
      pb_val_ff <= nxt_pb_val;
      pa_dir_ff <= nxt_pa_dir;
      pa_val_ff <= nxt_pa_val;
      pat_en_ff <= nxt_pat_en;
      tim_ff <= nxt_tim;
      clk_ff <= nxt_clk;
      sys_ff <= nxt_sys;
      pa_drv_ff <= nxt_pa_drv;
      pb_drv_ff <= nxt_pb_drv;
      cap_a_ff <= nxt_cap_a;
      cap_b_ff <= nxt_cap_b;
      ext_ff <= nxt_ext;
    end
  end

  // bus channel registers, kept alive through hardware standby
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= 20'h0_0000;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // two-stage pin synchronisers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pa_s1_ff <= 8'h00;
      pa_s2_ff <= 8'h00;
      pb_s1_ff <= 8'h00;
      pb_s2_ff <= 8'h00;
    end else begin
      pa_s1_ff <= PORT_A_IN;
      pa_s2_ff <= pa_s1_ff;
      pb_s1_ff <= PORT_B_IN;
      pb_s2_ff <= pb_s1_ff;
    end
  end

  // ready is high whenever the holding slot is free
  assign S_AXI_AWREADY = !aw_hold_ff;
  assign S_AXI_WREADY = !w_hold_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_ARREADY = !rvalid_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;
  assign PORT_A_OUT = pa_drv_ff.dout;
  assign PORT_A_OE = pa_drv_ff.oe;
  assign PORT_B_OUT = pb_drv_ff.dout;
  assign PORT_B_OE = pb_drv_ff.oe;
  assign TIMER_A_CAPTURE = cap_a_ff;
  assign TIMER_B_CAPTURE = cap_b_ff;
  assign EXT_CLOCK = ext_ff;

endmodule

// [include/pin_select_pkg.sv]
// Purpose: shared constants and carriers for the port A/B pin-function selector
// Assumes: 32-bit AXI4-Lite register bus, byte addresses taken from printed offsets
// Notes: offsets are the low 20 address bits of each register
package pin_select_pkg;

  localparam int ADDR_W = 20;
  localparam logic [19:0] PORT_B_DIRECTION_OFS = 20'hE_E00A;
  localparam logic [19:0] PORT_B_OUTPUT_VALUE_OFS = 20'hF_FFDA;
  // registers of our own for the loose control bits
  localparam logic [19:0] PORT_A_DIRECTION_OFS = 20'hE_E100;
  localparam logic [19:0] PORT_A_OUTPUT_VALUE_OFS = 20'hE_E104;
  localparam logic [19:0] PATTERN_ENABLE_OFS = 20'hE_E108;
  localparam logic [19:0] TIMER_SETUP_OFS = 20'hE_E10C;
  localparam logic [19:0] CLOCK_SETUP_OFS = 20'hE_E110;
  localparam logic [19:0] SYSTEM_SETUP_OFS = 20'hE_E114;
  localparam logic [19:0] PORT_A_PIN_OFS = 20'hE_E118;

  localparam logic [7:0] PORT_B_DIRECTION_RST = 8'h00;
  localparam logic [7:0] PORT_B_OUTPUT_VALUE_RST = 8'h00;
  localparam logic [7:0] PORT_A_DIRECTION_RST = 8'h00;
  localparam logic [7:0] WRITE_ONLY_READ = 8'hFF;
  localparam logic [31:0] TIMER_SETUP_RST = 32'h0000_0000;
  localparam logic [31:0] CLOCK_SETUP_RST = 32'h0000_0000;
  localparam logic [7:0] SYSTEM_SETUP_RST = 8'h0E;

  // timer setup field positions (per channel: a select at 3c, b select at 3c+9... )
  localparam int TS_A_SEL_POS = 0;   // 3 bits per channel, channels 0..2 at 0,3,6
  localparam int TS_B_SEL_POS = 9;   // 3 bits per channel at 9,12,15
  localparam int TS_DUTY_POS = 18;   // 3 bits, one per channel
  localparam int TS_PHASE_POS = 21;  // phase-counting mode bit
  // clock setup: 16-bit prescaler selects at 0,3,6; 8-bit selects ch0..3 at 9,12,15,18
  localparam int CS_PRE_POS = 0;
  localparam int CS_EIGHT_POS = 9;
  // system setup bits
  localparam int SS_EXPANDED = 0;    // modes 3/4
  localparam int SS_ADDR21_EN = 1;
  localparam int SS_ADDR22_EN = 2;
  localparam int SS_ADDR23_EN = 3;
  localparam int SS_DMA0_EXT = 4;
  localparam int SS_DMA1_EXT = 5;
  localparam int SS_DRAM = 6;

  localparam logic [2:0] PRE_CLK_A = 3'h4;
  localparam logic [2:0] PRE_CLK_B = 3'h5;
  localparam logic [2:0] PRE_CLK_C = 3'h6;
  localparam logic [2:0] PRE_CLK_D = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] a_select_field;
    logic [2:0] b_select_field;
    logic duty_mode_bit;
  } timer_chan_s;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } pin_drive_s;

endpackage
